// *** pkg/ecsi_defs.svh ***
// register offsets, field positions and reset values of the event channel status block
`ifndef ECSI_DEFS_SVH
`define ECSI_DEFS_SVH

`define ECSI_NUM_CH 12
`define ECSI_ADDR_W 8
`define ECSI_DATA_W 32
`define ECSI_OFF_USER_READY 8'h0c
`define ECSI_OFF_IRQ_EN_CLR 8'h10
`define ECSI_OFF_IRQ_EN_SET 8'h14
`define ECSI_OFF_IRQ_FLAG 8'h18
`define ECSI_OFF_PATH_CFG 8'h40
`define ECSI_OVR_LSB 0
`define ECSI_EVD_LSB 16
`define ECSI_RST_IRQ_EN 32'h00000000
`define ECSI_RST_IRQ_FLAG 32'h00000000
`define ECSI_RST_PATH_ASYNC 12'h000

`endif

// *** pkg/ecsi_pkg.sv ***
// types shared by the event channel status block
`default_nettype none
package ecsi_pkg;

    // per-channel activity from the channel datapath
    typedef struct packed {
        logic [11:0] evt_pass;
        logic [11:0] evt_collide;
        logic [11:0] users_ready;
    } ecsi_chan_t;

    // one register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ecsi_bus_req_t;

    // state of the per-channel overrun watcher
    typedef enum logic [1:0] {
        ECSI_IDLE = 2'b01,
        ECSI_PEND = 2'b10
    } ecsi_ovr_state_t;

endpackage : ecsi_pkg
`default_nettype wire

// *** src/ecsi_ovr_watch.sv ***
// per-channel overrun and event-detected event capture
`timescale 1ns/100ps
`default_nettype none
`include "ecsi_defs.svh"

module ecsi_ovr_watch (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic evt_pass_i,
    input wire logic evt_collide_i,
    input wire logic users_ready_i,
    input wire logic path_async_i,
    output logic evd_hit_o,
    output logic ovr_hit_o
);

    ecsi_pkg::ecsi_ovr_state_t state_q;

    // ------------------------------------------------
    // pending tracker: an event waits until users ready
    // ------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ecsi_pkg::ECSI_IDLE;
        end else begin
            unique case (state_q)
                ecsi_pkg::ECSI_IDLE: begin
                    if (evt_pass_i && !path_async_i && !users_ready_i) begin
                        state_q <= ecsi_pkg::ECSI_PEND;
                    end
                end
                ecsi_pkg::ECSI_PEND: begin
                    if (users_ready_i || path_async_i) begin
                        state_q <= ecsi_pkg::ECSI_IDLE;
                    end
                end
                default: begin
                    state_q <= ecsi_pkg::ECSI_IDLE;
                end
            endcase
        end
    end

    // event pulses, one cycle after cause; async path never flags
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evd_hit_o <= 1'b0;
            ovr_hit_o <= 1'b0;
        end else begin
            evd_hit_o <= evt_pass_i && !path_async_i;
            ovr_hit_o <= !path_async_i && ((evt_pass_i && !users_ready_i)
                         || (evt_pass_i && state_q == ecsi_pkg::ECSI_PEND)
                         || evt_collide_i);
        end
    end

endmodule : ecsi_ovr_watch
`default_nettype wire

// *** src/ecsi_top.sv ***
// event channel status, interrupt enables, flags and request output
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "ecsi_defs.svh"

module ecsi_top (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [31:0] bus_rdata_o,
    input wire ecsi_pkg::ecsi_chan_t chan_i,
    output logic [11:0] users_ready_o,
    output logic irq_o
);

    // ------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------
    // channel inputs come from other logic; users-ready lines are pins
    logic [11:0] rdy_s1_q;
    logic [11:0] rdy_s2_q;
    logic [11:0] rdy_s3_q;
    logic [11:0] rdy_q;

    // three stages; a change counts once stage two and three agree
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_s1_q <= 12'h000;
            rdy_s2_q <= 12'h000;
            rdy_s3_q <= 12'h000;
        end else begin
            rdy_s1_q <= chan_i.users_ready;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    // filtered level per channel
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_q <= 12'h000;
        end else begin
            rdy_q <= (rdy_s2_q & rdy_s3_q) | (rdy_q & (rdy_s2_q | rdy_s3_q));
        end
    end

    // ------------------------------------------------
    // register state
    // ------------------------------------------------
    logic [11:0] en_evd_q;
    logic [11:0] en_ovr_q;
    logic [11:0] flag_evd_q;
    logic [11:0] flag_ovr_q;
    logic [11:0] path_async_q;
    logic [11:0] evd_hit;
    logic [11:0] ovr_hit;
    logic wr_clr;
    logic wr_set;
    logic wr_flag;
    logic wr_path;
    logic [11:0] wd_evd;
    logic [11:0] wd_ovr;

    // reset words cut per field, so each 12-bit vector takes only its own bits
    localparam logic [31:0] rst_en_w = `ECSI_RST_IRQ_EN;
    localparam logic [31:0] rst_flag_w = `ECSI_RST_IRQ_FLAG;

    // write decode
    assign wr_clr = bus_wr_i && (bus_addr_i == `ECSI_OFF_IRQ_EN_CLR);
    assign wr_set = bus_wr_i && (bus_addr_i == `ECSI_OFF_IRQ_EN_SET);
    assign wr_flag = bus_wr_i && (bus_addr_i == `ECSI_OFF_IRQ_FLAG);
    assign wr_path = bus_wr_i && (bus_addr_i == `ECSI_OFF_PATH_CFG);
    assign wd_evd = bus_wdata_i[`ECSI_EVD_LSB +: `ECSI_NUM_CH];
    assign wd_ovr = bus_wdata_i[`ECSI_OVR_LSB +: `ECSI_NUM_CH];

    // ------------------------------------------------
    // per-channel event capture
    // ------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `ECSI_NUM_CH; ch = ch + 1) begin : g_ch
            ecsi_ovr_watch u_watch (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .evt_pass_i(chan_i.evt_pass[ch]),
                .evt_collide_i(chan_i.evt_collide[ch]),
                .users_ready_i(rdy_q[ch]),
                .path_async_i(path_async_q[ch]),
                .evd_hit_o(evd_hit[ch]),
                .ovr_hit_o(ovr_hit[ch])
            );
        end
    endgenerate

    // path selection per channel; one marks the asynchronous path
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            path_async_q <= `ECSI_RST_PATH_ASYNC;
        end else if (wr_path) begin
            path_async_q <= bus_wdata_i[11:0];
        end
    end

    // ------------------------------------------------
    // interrupt enables, one vector behind set and clear
    // ------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_evd_q <= rst_en_w[`ECSI_EVD_LSB +: `ECSI_NUM_CH];
            en_ovr_q <= rst_en_w[`ECSI_OVR_LSB +: `ECSI_NUM_CH];
        end else begin
            // zero bits leave enables alone
            if (wr_clr) begin
                en_evd_q <= en_evd_q & ~wd_evd;
                en_ovr_q <= en_ovr_q & ~wd_ovr;
            end else if (wr_set) begin
                en_evd_q <= en_evd_q | wd_evd;
                en_ovr_q <= en_ovr_q | wd_ovr;
            end
        end
    end

    // ------------------------------------------------
    // sticky flags; a fresh event beats a clear in the same cycle
    // ------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_evd_q <= rst_flag_w[`ECSI_EVD_LSB +: `ECSI_NUM_CH];
            flag_ovr_q <= rst_flag_w[`ECSI_OVR_LSB +: `ECSI_NUM_CH];
        end else begin
            flag_evd_q <= (flag_evd_q & ~(wr_flag ? wd_evd : 12'h000)) | evd_hit;
            flag_ovr_q <= (flag_ovr_q & ~(wr_flag ? wd_ovr : 12'h000)) | ovr_hit;
        end
    end

    // ------------------------------------------------
    // interrupt and status outputs
    // ------------------------------------------------
    // level request; set flag changes show one cycle later
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            users_ready_o <= 12'h000;
        end else begin
            irq_o <= |(flag_evd_q & en_evd_q) | |(flag_ovr_q & en_ovr_q);
            users_ready_o <= rdy_q;
        end
    end

    // ------------------------------------------------
    // read port, data valid in the cycle after the strobe
    // ------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 32'h00000000;
        end else if (bus_rd_i) begin
            unique case (bus_addr_i)
                `ECSI_OFF_USER_READY: bus_rdata_o <= {20'h00000, rdy_q};
                `ECSI_OFF_IRQ_EN_CLR,
                `ECSI_OFF_IRQ_EN_SET: bus_rdata_o <= {4'h0, en_evd_q, 4'h0, en_ovr_q};
                `ECSI_OFF_IRQ_FLAG: bus_rdata_o <= {4'h0, flag_evd_q, 4'h0, flag_ovr_q};
                `ECSI_OFF_PATH_CFG: bus_rdata_o <= {20'h00000, path_async_q};
                default: bus_rdata_o <= 32'h00000000; // unmapped reads zero
            endcase
        end else begin
            bus_rdata_o <= 32'h00000000;
        end
    end

endmodule : ecsi_top
`default_nettype wire

// *** test/ecsi_monitor.sv ***
// port checker for the event channel status block
`timescale 1ns/100ps
`default_nettype none
module ecsi_monitor (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [31:0] bus_rdata_o,
    input wire ecsi_pkg::ecsi_chan_t chan_i,
    input wire logic [11:0] users_ready_o,
    input wire logic irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [31:0] en_q;
    logic [11:0] async_q;
    // shadow enables and async selects, rebuilt from bus writes only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 32'h0;
            async_q <= 12'h0;
        end else if (bus_wr_i && bus_addr_i == 8'h14) begin
            en_q <= en_q | (bus_wdata_i & 32'h0fff0fff);
        end else if (bus_wr_i && bus_addr_i == 8'h10) begin
            en_q <= en_q & ~bus_wdata_i;
        end else if (bus_wr_i && bus_addr_i == 8'h40) begin
            async_q <= bus_wdata_i[11:0];
        end
    end
    // no event traffic in a cycle
    sequence quiet_s;
        chan_i.evt_pass == 12'h0 && chan_i.evt_collide == 12'h0;
    endsequence
    // software clears every flag at once
    sequence clear_all_s;
        bus_wr_i && bus_addr_i == 8'h18 && bus_wdata_i == 32'h0fff0fff;
    endsequence
    a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 32'h0)
        else $error("read data outside slot");
    a_en_readback: assert property (bus_rd_i && (bus_addr_i == 8'h10 || bus_addr_i == 8'h14) |=> bus_rdata_o == en_q)
        else $error("enable readback wrong");
    a_ready_high: assert property ((chan_i.users_ready == 12'hfff) [*6] |-> users_ready_o == 12'hfff)
        else $error("users ready not high");
    a_ready_low: assert property ((!chan_i.users_ready[2]) [*6] |-> !users_ready_o[2])
        else $error("users ready not low");
    a_evd_irq: assert property (chan_i.evt_pass[0] && en_q[16] && !async_q[0] ##0 (!bus_wr_i) [*3] |-> ##1 irq_o)
        else $error("event irq missing");
    a_ovr_irq: assert property (chan_i.evt_collide[1] && en_q[1] && !async_q[1] ##0 (!bus_wr_i) [*3] |-> ##1 irq_o)
        else $error("overrun irq missing");
    a_irq_masked: assert property (en_q == 32'h0 && $past(en_q) == 32'h0 |-> !irq_o)
        else $error("irq without enable");
    a_clear_drop: assert property (quiet_s [*3] ##0 clear_all_s |=> ##1 !irq_o)
        else $error("irq after full clear");
endmodule : ecsi_monitor
`default_nettype wire

// *** test/ecsi_partner.sv ***
// far-side model: event generators and users of the twelve channels
`timescale 1ns/100ps
`default_nettype none
module ecsi_partner (
    input wire logic mclk_i,
    input wire logic [11:0] pass_i,
    input wire logic [11:0] coll_i,
    input wire logic [11:0] rdy_i,
    output var ecsi_pkg::ecsi_chan_t chan_o
);
    // generators pulse on the bus clock; users report ready as a level
    always_ff @(posedge mclk_i) begin
        chan_o <= {pass_i, coll_i, rdy_i};
    end
endmodule : ecsi_partner
`default_nettype wire

// *** test/event_channel_status_irq_test.sv ***
// self-checking bench for the event channel status block
`timescale 1ns/100ps
`default_nettype none
module event_channel_status_irq_test;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [11:0] pas = 12'h0;
    logic [11:0] col = 12'h0;
    logic [11:0] rdy = 12'hfff;
    logic [11:0] urdy;
    logic irq;
    ecsi_pkg::ecsi_chan_t chan;
    int bad_count = 0;
    int compares = 0;
    // rows: write address, write data, read address, expected word
    logic [79:0] rows [7] = '{
        {8'h14, 32'h0fff0fff, 8'h10, 32'h0fff0fff},
        {8'h10, 32'h00010001, 8'h14, 32'h0ffe0ffe},
        {8'h14, 32'h00000000, 8'h10, 32'h0ffe0ffe},
        {8'h10, 32'hffffffff, 8'h14, 32'h00000000},
        {8'h20, 32'hffffffff, 8'h20, 32'h00000000},
        {8'h14, 32'hf0010002, 8'h10, 32'h00010002},
        {8'h10, 32'h00000000, 8'h0c, 32'h00000fff}};
    ecsi_top ecsi_top_inst (.mclk_i, .rst_n_i, .bus_addr_i(adr), .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd),
        .bus_rdata_o(rdat), .chan_i(chan), .users_ready_o(urdy), .irq_o(irq));
    ecsi_partner ecsi_partner_inst (.mclk_i, .pass_i(pas), .coll_i(col), .rdy_i(rdy), .chan_o(chan));
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wr32
    // read data stand only in the cycle after the strobe
    task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        adr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk(exp, rdat, "read data");
    endtask : rd32
    // one-cycle pulses, then room for flag and irq to land
    task automatic fire(input logic [11:0] p, input logic [11:0] c);
        @(posedge mclk_i);
        pas <= p;
        col <= c;
        @(posedge mclk_i);
        pas <= 12'h0;
        col <= 12'h0;
        repeat (6) @(posedge mclk_i);
        #1;
    endtask : fire
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    // hang guard
    initial begin
        #2000000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            wr32(rows[i][79:72], rows[i][71:40]);
            rd32(rows[i][39:32], rows[i][31:0]);
        end
        @(posedge mclk_i);
        rdy <= 12'hffb;
        repeat (8) @(posedge mclk_i);
        rd32(8'h0c, 32'h00000ffb);
        chk(32'h00000ffb, {20'h0, urdy}, "users ready out");
        fire(12'h002, 12'h0);
        chk(32'h0, {31'h0, irq}, "masked irq");
        fire(12'h001, 12'h0);
        chk(32'h1, {31'h0, irq}, "irq");
        rd32(8'h18, 32'h00030000);
        wr32(8'h18, 32'h00020000);
        wr32(8'h18, 32'h0);
        rd32(8'h18, 32'h00010000);
        wr32(8'h18, 32'h00010000);
        rd32(8'h18, 32'h0);
        repeat (2) @(posedge mclk_i);
        #1 chk(32'h0, {31'h0, irq}, "cleared irq");
        fire(12'h004, 12'h002);
        rd32(8'h18, 32'h00040006);
        chk(32'h1, {31'h0, irq}, "overrun irq");
        @(posedge mclk_i);
        rdy <= 12'hfff;
        wr32(8'h18, 32'h0fff0fff);
        rd32(8'h18, 32'h0);
        wr32(8'h40, 32'h00000003);
        fire(12'h003, 12'h003);
        rd32(8'h18, 32'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        #1 chk(32'h0, {19'h0, urdy, irq}, "outputs in reset");
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd32(8'h14, 32'h0);
        rd32(8'h18, 32'h0);
        rd32(8'h40, 32'h0);
        summarize();
    end
endmodule : event_channel_status_irq_test
bind ecsi_top ecsi_monitor ecsi_monitor_inst (.mclk_i, .rst_n_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i,
    .bus_rdata_o, .chan_i, .users_ready_o, .irq_o);
`default_nettype wire
